// file: rtl/pss_flag_bit.sv
`timescale 1ns/1ns
`default_nettype none
module pss_flag_bit
  import pss_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic set_evt,
  input  wire logic clr_ack,
  output logic      flag
);

  logic flag_ff;
  logic nxt_flag;

  // Set beats clear in the same cycle
  assign nxt_flag = set_evt | (flag_ff & ~clr_ack);
  assign flag     = flag_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

endmodule : pss_flag_bit
`default_nettype wire

// file: rtl/pss_status_word.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R1] Hybrid-request flag bit 11 sets only in hybrid mode, else cleared.
// [R2] While hybrid flag set, bits 4 and 5 carry intrusive-mode meaning.
// [R3] Bit 12 sets when a requested power role swap finishes, any outcome.
// [R4] Software judges swap success from the power direction bit.
// [R5] Bit 13 sets on vendor message; software then fetches it by command.
// [R6] Reserved bit 14 always reads zero.
// [R7] Bit 15 sets on an unidentified port error.
// [R8] Bit 16 copies supply type from partner capabilities; zero means none.
// [R9] Bits 17-19 encode mode: none, legacy, battery charging, power delivery.
// [R10] Mode and supply fields show current values when change bits 2, 1 set; here the change pulses come one cycle before the fields update.
// [R11] Bit 5 means direction changed, or partner swap request when intrusive.
// [R12] Change flags 12, 13, 15 stay set until software acknowledges them; 11 also clears outside hybrid mode.
module pss_status_word
  import pss_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire pss_hub_mode_t hub_mode,
  input  wire logic          hybrid_req_evt,
  input  wire logic          swap_done_evt,
  input  wire logic          vendor_msg_evt,
  input  wire logic          error_evt,
  input  wire logic          cap_supply_bit,
  input  wire logic          cap_valid,
  input  wire pss_opm_t      port_opm,
  input  wire logic          level_chg_evt,
  input  wire logic          dir_chg_evt,
  input  wire logic [4:0]    ack_flags,
  output logic [19:11]       status_word,
  output logic               level_chg_intrusive,
  output logic               dir_chg_swap_request,
  output logic               supply_chg_evt,
  output logic               opm_chg_evt
);


  // Reset release synchroniser
  logic        rst_sync1_ff;
  logic        rst_sync2_ff;
  logic        rst_n;

  // Supply and mode field registers
  logic        supply_ff;
  logic        nxt_supply;
  pss_opm_t    opm_ff;
  pss_opm_t    nxt_opm;
  logic        supply_differs;
  logic        opm_differs;

  // Sticky change flags
  logic [4:0]  flag_set;
  logic [4:0]  flag_clr;
  // Bit 3 is held clear
  logic [4:0]  flag_q;

  // Mode decode and word assembly
  logic        mode_hybrid;
  logic        mode_intrusive;
  logic        intrusive_view;
  pss_word_t   word;

  // Mode compare used by several decodes
  function automatic logic mode_is
  (
    input pss_hub_mode_t cur,
    input pss_hub_mode_t want
  );
    return (cur == want);
  endfunction : mode_is

  // Reset release, first stage
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync1_ff <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
    end
  end

  // Second stage only reads the first
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync2_ff <= 1'b0;
    end
    else
    begin
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // Internal reset copy
  assign rst_n = rst_sync2_ff;

  // Hub mode decode
  // Unused encoding decodes as neither
  assign mode_hybrid    = mode_is(hub_mode, PSS_HUB_HYBRID);
  assign mode_intrusive = mode_is(hub_mode, PSS_HUB_INTRUSIVE);

  // [R1] Hybrid flag gated by mode
  assign flag_set[0] = hybrid_req_evt & mode_hybrid;
  // [R1] Cleared outside hybrid mode
  assign flag_clr[0] = ack_flags[0] | ~mode_hybrid;

  // [R3] Swap completion flag
  assign flag_set[1] = swap_done_evt;
  assign flag_clr[1] = ack_flags[1];

  // [R5] Vendor message flag
  assign flag_set[2] = vendor_msg_evt;
  assign flag_clr[2] = ack_flags[2];

  // [R6] Reserved never set
  // Cell kept for uniform indexing
  assign flag_set[3] = 1'b0;
  assign flag_clr[3] = 1'b1;

  // [R7] Error flag
  assign flag_set[4] = error_evt;
  assign flag_clr[4] = ack_flags[4];

  // [R12] Sticky flags until acknowledged
  // Set beats clear in each cell
  genvar gi;
  generate
    for (gi = 0; gi < PSS_NUM_FLAGS; gi++)
    begin : g_flag
      pss_flag_bit u_flag
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set_evt (flag_set[gi]),
        .clr_ack (flag_clr[gi]),
        .flag    (flag_q[gi])
      );
    end
  endgenerate

  // [R8] Supply copied from capabilities
  assign nxt_supply = cap_valid ? cap_supply_bit : supply_ff;

  // [R9] Mode follows the port each cycle
  assign nxt_opm = port_opm;

  // [R8] Supply field register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      supply_ff <= PSS_SUPPLY_RST;
    end
    else
    begin
      supply_ff <= nxt_supply;
    end
  end

  // [R9] Mode field register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opm_ff <= PSS_OPM_RST;
    end
    else
    begin
      opm_ff <= nxt_opm;
    end
  end

  // [R10] Field update detection
  assign supply_differs = (nxt_supply != supply_ff);
  assign opm_differs    = (nxt_opm != opm_ff);

  // [R10] Change pulses held off in reset
  assign supply_chg_evt = rst_n & supply_differs;
  assign opm_chg_evt    = rst_n & opm_differs;

  // [R2] Intrusive reading of bits 4,5
  assign intrusive_view      = flag_q[0] | mode_intrusive;
  assign level_chg_intrusive = level_chg_evt & intrusive_view;

  // [R11] Bit 5 meaning select
  assign dir_chg_swap_request = dir_chg_evt & intrusive_view;

  // [R1] Hybrid request bit
  assign word.hybrid_req = flag_q[0];

  // [R3] Swap done bit
  assign word.swap_done  = flag_q[1];

  // [R5] Vendor message bit
  assign word.vendor_msg = flag_q[2];

  // [R6] Reserved bit zero
  assign word.rsvd14     = 1'b0;

  // [R7] Error bit
  assign word.error      = flag_q[4];

  // [R8] Supply bit
  assign word.supply     = supply_ff;

  // [R9] Mode field
  assign word.opm        = opm_ff;

  // Word section out
  assign status_word = word;

endmodule : pss_status_word
`default_nettype wire

// file: shared/pss_pkg.sv
`default_nettype none
package pss_pkg;

  // Hub operating modes
  typedef enum logic [1:0] {
    PSS_HUB_NON_INTRUSIVE = 2'h0,
    PSS_HUB_INTRUSIVE     = 2'h1,
    PSS_HUB_HYBRID        = 2'h3
  } pss_hub_mode_t;

  // Port operation mode encodings
  typedef enum logic [2:0] {
    PSS_OPM_NO_CONSUMER = 3'h0,
    PSS_OPM_LEGACY      = 3'h1,
    PSS_OPM_BATTERY_CHG = 3'h2,
    PSS_OPM_POWER_DLV   = 3'h3
  } pss_opm_t;

  // Bit positions in the status word
  localparam int PSS_BIT_SUPPLY_CHG = 1;
  localparam int PSS_BIT_OPM_CHG    = 2;
  localparam int PSS_BIT_LEVEL_CHG  = 4;
  localparam int PSS_BIT_DIR_CHG    = 5;
  localparam int PSS_BIT_HYBRID_REQ = 11;
  localparam int PSS_BIT_SWAP_DONE  = 12;
  localparam int PSS_BIT_VENDOR_MSG = 13;
  localparam int PSS_BIT_RSVD14     = 14;
  localparam int PSS_BIT_ERROR      = 15;
  localparam int PSS_BIT_SUPPLY     = 16;
  localparam int PSS_BIT_OPM_LO     = 17;
  localparam int PSS_BIT_OPM_HI     = 19;
  localparam int PSS_NUM_FLAGS      = 5;

  // Reset values
  localparam logic [PSS_NUM_FLAGS-1:0] PSS_FLAGS_RST  = 5'h00;
  localparam logic                     PSS_SUPPLY_RST = 1'h0;
  localparam pss_opm_t                 PSS_OPM_RST    = PSS_OPM_NO_CONSUMER;

  // Hub events for the flag group
  typedef struct packed {
    logic hybrid_req;
    logic swap_done;
    logic vendor_msg;
    logic error;
  } pss_events_t;

  // Status word section for bits 11..19
  typedef struct packed {
    pss_opm_t opm;
    logic     supply;
    logic     error;
    logic     rsvd14;
    logic     vendor_msg;
    logic     swap_done;
    logic     hybrid_req;
  } pss_word_t;

endpackage : pss_pkg
`default_nettype wire

// file: tb/pss_spm_model.sv
`timescale 1ns/1ns
`default_nettype none
module pss_spm_model
(
  input  wire logic         ack_en,
  input  wire logic [19:11] status_word,
  output logic [4:0]        ack_flags
);
  assign ack_flags = ack_en ? status_word[15:11] : 5'h00;
endmodule : pss_spm_model
`default_nettype wire

// file: tb/pss_status_word_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pss_status_word_checker
  import pss_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          resetn,
  input wire pss_hub_mode_t hub_mode,
  input wire logic          hybrid_req_evt,
  input wire logic          swap_done_evt,
  input wire logic          error_evt,
  input wire logic          cap_valid,
  input wire logic          cap_supply_bit,
  input wire pss_opm_t      port_opm,
  input wire logic          level_chg_evt,
  input wire logic [4:0]    ack_flags,
  input wire logic [19:11]  status_word,
  input wire logic          level_chg_intrusive,
  input wire logic          dir_chg_swap_request,
  input wire logic          vendor_msg_evt,
  input wire logic          supply_chg_evt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_hybrid_mode: assert property ($rose(status_word[11]) |->
    $past(hub_mode) == PSS_HUB_HYBRID) else $error("hybrid flag outside hybrid");
  chk_swap_set: assert property (swap_done_evt |=> status_word[12])
    else $error("swap flag missing");
  chk_rsvd_zero: assert property (!status_word[14]) else $error("bit 14 set");
  chk_error_set: assert property (error_evt |=> status_word[15])
    else $error("error flag missing");
  chk_supply_copy: assert property (cap_valid |=>
    status_word[16] == $past(cap_supply_bit)) else $error("supply not copied");
  chk_opm_follow: assert property ($changed(port_opm) |=>
    status_word[19:17] == $past(port_opm)) else $error("mode field stale");
  chk_swap_hold: assert property (status_word[12] && !ack_flags[1] |=>
    status_word[12]) else $error("swap flag lost");
  chk_level_meaning: assert property (level_chg_evt && status_word[11] |->
    level_chg_intrusive) else $error("level meaning wrong");
  chk_dir_plain: assert property (hub_mode == PSS_HUB_NON_INTRUSIVE &&
    !status_word[11] |-> !dir_chg_swap_request) else $error("dir meaning wrong");
  chk_hybrid_clear: assert property (hub_mode != PSS_HUB_HYBRID |=>
    !status_word[11]) else $error("hybrid flag kept outside hybrid");
  chk_vendor_set: assert property (vendor_msg_evt |=> status_word[13])
    else $error("vendor flag missing");
  chk_supply_pulse: assert property (cap_valid && cap_supply_bit != status_word[16]
    |-> supply_chg_evt) else $error("supply change pulse missing");
endmodule : pss_status_word_checker
bind pss_status_word pss_status_word_checker chk (.*);
`default_nettype wire

// file: tb/tb_pss_status_word.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pss_status_word
  import pss_pkg::*;
;
  logic          clk_sys = 0, resetn = 0, cap_supply_bit = 0, cap_valid = 0;
  logic          level_chg_evt = 0, dir_chg_evt = 0, ack_en = 0, lci, dsr;
  pss_hub_mode_t hub_mode = PSS_HUB_NON_INTRUSIVE;
  pss_opm_t      port_opm = PSS_OPM_NO_CONSUMER;
  pss_events_t   ev = '0;
  logic [4:0]    ack_flags;
  logic          sce, oce;
  logic [19:11]  status_word;
  int            failures = 0, num_checks = 0;
  pss_status_word uut (.clk_sys, .resetn, .hub_mode, .hybrid_req_evt(ev.hybrid_req),
    .swap_done_evt(ev.swap_done), .vendor_msg_evt(ev.vendor_msg), .error_evt(ev.error),
    .cap_supply_bit, .cap_valid, .port_opm, .level_chg_evt, .dir_chg_evt, .ack_flags,
    .status_word, .level_chg_intrusive(lci), .dir_chg_swap_request(dsr),
    .supply_chg_evt(sce), .opm_chg_evt(oce));
  pss_spm_model spm (.ack_en, .status_word, .ack_flags);
  always #50 clk_sys = ~clk_sys;
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task fire(input pss_events_t e);
    ev = e;
    tick(1);
    ev = '0;
    tick(1);
  endtask : fire
  task ack;
    ack_en = 1;
    tick(1);
    ack_en = 0;
    tick(1);
  endtask : ack
  initial
  begin
    tick(6);
    resetn = 1;
    tick(3);
    fire(4'b0010);
    chk("vendor", 9'h004, status_word);
    ack();
    chk("cleared", 9'h000, status_word);
    fire(4'b1101);
    hub_mode = PSS_HUB_INTRUSIVE;
    fire(4'b1000);
    chk("swap err", 9'h012, status_word);
    ack();
    hub_mode = PSS_HUB_HYBRID;
    level_chg_evt = 1;
    dir_chg_evt = 1;
    fire(4'b1000);
    chk("hybrid", 9'h001, status_word);
    chk("meaning", 9'h003, {7'h00, lci, dsr});
    hub_mode = PSS_HUB_NON_INTRUSIVE;
    tick(2);
    chk("hybrid drop", 9'h000, status_word);
    ack();
    chk("plain", 9'h000, {7'h00, lci, dsr});
    cap_supply_bit = 1;
    cap_valid = 1;
    #1 chk("supply pulse", 9'h001, {8'h00, sce});
    tick(1);
    cap_valid = 0;
    cap_supply_bit = 0;
    tick(1);
    chk("supply", 9'h020, status_word);
    for (int m = 0; m < 4; m++)
    begin
      port_opm = pss_opm_t'(m);
      #1 chk("opm pulse", {8'h00, m != 0}, {8'h00, oce});
      tick(2);
      chk("opm", {m[2:0], 6'h20}, status_word);
    end
    results();
  end
  initial
  begin
    #100000;
    failures++;
    results();
  end
endmodule : tb_pss_status_word
`default_nettype wire
